/* rtl/dpc_map.vh */
// Address map, field positions and reset values of the position capture unit
`ifndef DPC_MAP_VH
`define DPC_MAP_VH

`define DPC_ADDR_W 16
`define DPC_POS_W 32
`define DPC_CNT_W 16
`define DPC_WORD_W 16

`define DPC_OFS_IN1_RISE_POS 16'h0A4A
`define DPC_OFS_IN1_FALL_POS 16'h0A4C
`define DPC_OFS_IN2_RISE_POS 16'h0A4E
`define DPC_OFS_IN2_FALL_POS 16'h0A50
`define DPC_OFS_IN1_RISE_CNT 16'h0A56
`define DPC_OFS_IN1_FALL_CNT 16'h0A58
`define DPC_OFS_IN2_RISE_CNT 16'h0A5A
`define DPC_OFS_IN2_FALL_CNT 16'h0A5C
`define DPC_OFS_SUMMARY 16'h0A5E
`define DPC_OFS_CTRL 16'h1B74
`define DPC_OFS_STAT 16'h1B76

`define DPC_CH_STRIDE 8
`define DPC_CTL_ACT 0
`define DPC_CTL_CONT 1
`define DPC_CTL_RISE_EN 4
`define DPC_CTL_FALL_EN 5
`define DPC_CTL_MASK 16'h3333

`define DPC_ST_ACT 0
`define DPC_ST_RISE 1
`define DPC_ST_FALL 2

`define DPC_SUM_NIB_W 4

`define DPC_CTRL_RST 16'h0000
`define DPC_POS_RST 32'h00000000
`define DPC_CNT_RST 16'h0000

`endif

/* rtl/dpc_sync.v */
// Input synchroniser with rising and falling edge detection
`timescale 1ns/1ps
module dpc_sync (
	input wire i_ref_clk,
	input wire i_sys_rst,
	input wire i_din,
	output wire o_rise,
	output wire o_fall
);

reg meta_r;
reg sync_r;
reg last_r;

always @(posedge i_ref_clk) begin
	if (i_sys_rst) begin
		meta_r <= 1'b0;
		sync_r <= 1'b0;
		last_r <= 1'b0;
	end else begin
		meta_r <= i_din;
		sync_r <= meta_r;
		last_r <= sync_r;
	end
end

assign o_rise = sync_r & ~last_r;
assign o_fall = ~sync_r & last_r;

endmodule // dpc_sync

/* rtl/dpc_cnt.v */
// Wrapping event counter with synchronous clear
`timescale 1ns/1ps
`include "dpc_map.vh"
module dpc_cnt #(
	parameter W = `DPC_CNT_W
) (
	input wire i_ref_clk,
	input wire i_sys_rst,
	input wire i_clr,
	input wire i_inc,
	output reg [W-1:0] o_cnt
);

always @(posedge i_ref_clk) begin
	if (i_sys_rst) begin
		o_cnt <= {W{1'b0}};
	end else if (i_clr) begin
		o_cnt <= {W{1'b0}};
	end else if (i_inc) begin
		o_cnt <= o_cnt + {{(W-1){1'b0}}, 1'b1};
	end
end

endmodule // dpc_cnt

/* rtl/dpc_top.v */
// Two-channel position capture unit with parameter read/write port
`timescale 1ns/1ps
`include "dpc_map.vh"
module dpc_top #(
	parameter POS_W = `DPC_POS_W,
	parameter CNT_W = `DPC_CNT_W
) (
	input wire i_ref_clk,
	input wire i_sys_rst,
	input wire i_capture_input_one,
	input wire i_capture_input_two,
	input wire [POS_W-1:0] i_motor_pos,
	input wire i_pos_redef,
	input wire [POS_W-1:0] i_pos_shift,
	input wire [`DPC_ADDR_W-1:0] i_reg_addr,
	input wire i_reg_rd,
	input wire i_reg_wr,
	input wire [`DPC_WORD_W-1:0] i_reg_wdata,
	output reg [31:0] o_reg_rdata,
	output reg o_reg_ack,
	output reg o_reg_err
);

////////////////////////////////////////////////////////////////////////////////
// Control word and per-channel state

reg [`DPC_WORD_W-1:0] capture_control_word_r;
reg [1:0] act_d_r;
wire [1:0] cap_in;
wire [1:0] edge_rise;
wire [1:0] edge_fall;
wire [2*POS_W-1:0] rise_pos_w;
wire [2*POS_W-1:0] fall_pos_w;
wire [2*CNT_W-1:0] rise_cnt_w;
wire [2*CNT_W-1:0] fall_cnt_w;
wire [1:0] rise_flag_w;
wire [1:0] fall_flag_w;
wire [1:0] act_w;
wire [`DPC_WORD_W-1:0] capture_status_word;
wire [`DPC_WORD_W-1:0] packed_event_count_summary;

assign cap_in = {i_capture_input_two, i_capture_input_one};

always @(posedge i_ref_clk) begin
	if (i_sys_rst) begin
		act_d_r <= 2'b00;
	end else begin
		act_d_r <= act_w;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Capture channels

genvar g;
generate
	for (g = 0; g < 2; g = g + 1) begin : g_ch
		wire act;
		wire cont;
		wire rise_en;
		wire fall_en;
		wire arm;
		wire live;
		wire do_rise;
		wire do_fall;
		reg [POS_W-1:0] rise_pos_r;
		reg [POS_W-1:0] fall_pos_r;
		reg rise_flag_r;
		reg fall_flag_r;

		assign act = capture_control_word_r[g*`DPC_CH_STRIDE + `DPC_CTL_ACT];
		assign cont = capture_control_word_r[g*`DPC_CH_STRIDE + `DPC_CTL_CONT];
		assign rise_en = capture_control_word_r[g*`DPC_CH_STRIDE + `DPC_CTL_RISE_EN];
		assign fall_en = capture_control_word_r[g*`DPC_CH_STRIDE + `DPC_CTL_FALL_EN];
		assign arm = act & ~act_d_r[g];
		assign live = act & act_d_r[g];
		assign do_rise = live & rise_en & edge_rise[g] & (cont | ~rise_flag_r);
		assign do_fall = live & fall_en & edge_fall[g] & (cont | ~fall_flag_r);

		dpc_sync u_sync (
			.i_ref_clk(i_ref_clk),
			.i_sys_rst(i_sys_rst),
			.i_din(cap_in[g]),
			.o_rise(edge_rise[g]),
			.o_fall(edge_fall[g])
		);

		always @(posedge i_ref_clk) begin
			if (i_sys_rst) begin
				rise_pos_r <= `DPC_POS_RST;
				fall_pos_r <= `DPC_POS_RST;
			end else begin
				if (do_rise) begin
					rise_pos_r <= i_motor_pos;
				end else if (i_pos_redef) begin
					rise_pos_r <= rise_pos_r + i_pos_shift;
				end
				if (do_fall) begin
					fall_pos_r <= i_motor_pos;
				end else if (i_pos_redef) begin
					fall_pos_r <= fall_pos_r + i_pos_shift;
				end
			end
		end

		always @(posedge i_ref_clk) begin
			if (i_sys_rst) begin
				rise_flag_r <= 1'b0;
				fall_flag_r <= 1'b0;
			end else if (arm) begin
				rise_flag_r <= 1'b0;
				fall_flag_r <= 1'b0;
			end else begin
				if (do_rise) begin
					rise_flag_r <= 1'b1;
				end
				if (do_fall) begin
					fall_flag_r <= 1'b1;
				end
			end
		end

		dpc_cnt #(
			.W(CNT_W)
		) u_rise_cnt (
			.i_ref_clk(i_ref_clk),
			.i_sys_rst(i_sys_rst),
			.i_clr(arm),
			.i_inc(do_rise),
			.o_cnt(rise_cnt_w[g*CNT_W +: CNT_W])
		);

		dpc_cnt #(
			.W(CNT_W)
		) u_fall_cnt (
			.i_ref_clk(i_ref_clk),
			.i_sys_rst(i_sys_rst),
			.i_clr(arm),
			.i_inc(do_fall),
			.o_cnt(fall_cnt_w[g*CNT_W +: CNT_W])
		);

		assign act_w[g] = act;
		assign rise_pos_w[g*POS_W +: POS_W] = rise_pos_r;
		assign fall_pos_w[g*POS_W +: POS_W] = fall_pos_r;
		assign rise_flag_w[g] = rise_flag_r;
		assign fall_flag_w[g] = fall_flag_r;
		assign capture_status_word[g*`DPC_CH_STRIDE + `DPC_ST_ACT] = act;
		assign capture_status_word[g*`DPC_CH_STRIDE + `DPC_ST_RISE] = rise_flag_r;
		assign capture_status_word[g*`DPC_CH_STRIDE + `DPC_ST_FALL] = fall_flag_r;
		assign capture_status_word[g*`DPC_CH_STRIDE + 7 -: 5] = 5'h00;
		assign packed_event_count_summary[g*8 +: 4] =
			rise_cnt_w[g*CNT_W +: `DPC_SUM_NIB_W];
		assign packed_event_count_summary[g*8 + 4 +: 4] =
			fall_cnt_w[g*CNT_W +: `DPC_SUM_NIB_W];
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Parameter read/write port

function [31:0] dpc_zx16;
	input [CNT_W-1:0] v;
	begin
		dpc_zx16 = {{(32-CNT_W){1'b0}}, v};
	end
endfunction

reg [31:0] rd_val;
reg rd_hit;

always @* begin
	rd_val = 32'h00000000;
	rd_hit = 1'b1;
	case (i_reg_addr)
		`DPC_OFS_IN1_RISE_POS: rd_val = rise_pos_w[0 +: POS_W];
		`DPC_OFS_IN1_FALL_POS: rd_val = fall_pos_w[0 +: POS_W];
		`DPC_OFS_IN2_RISE_POS: rd_val = rise_pos_w[POS_W +: POS_W];
		`DPC_OFS_IN2_FALL_POS: rd_val = fall_pos_w[POS_W +: POS_W];
		`DPC_OFS_IN1_RISE_CNT: rd_val = dpc_zx16(rise_cnt_w[0 +: CNT_W]);
		`DPC_OFS_IN1_FALL_CNT: rd_val = dpc_zx16(fall_cnt_w[0 +: CNT_W]);
		`DPC_OFS_IN2_RISE_CNT: rd_val = dpc_zx16(rise_cnt_w[CNT_W +: CNT_W]);
		`DPC_OFS_IN2_FALL_CNT: rd_val = dpc_zx16(fall_cnt_w[CNT_W +: CNT_W]);
		`DPC_OFS_SUMMARY: rd_val = {16'h0000, packed_event_count_summary};
		`DPC_OFS_CTRL: rd_val = {16'h0000, capture_control_word_r};
		`DPC_OFS_STAT: rd_val = {16'h0000, capture_status_word};
		default: rd_hit = 1'b0;
	endcase
end

always @(posedge i_ref_clk) begin
	if (i_sys_rst) begin
		capture_control_word_r <= `DPC_CTRL_RST;
		o_reg_rdata <= 32'h00000000;
		o_reg_ack <= 1'b0;
		o_reg_err <= 1'b0;
	end else begin
		o_reg_ack <= 1'b0;
		o_reg_err <= 1'b0;
		if (i_reg_wr) begin
			if (i_reg_addr == `DPC_OFS_CTRL) begin
				capture_control_word_r <= i_reg_wdata & `DPC_CTL_MASK;
				o_reg_ack <= 1'b1;
			end else begin
				o_reg_err <= 1'b1;
			end
		end else if (i_reg_rd) begin
			if (rd_hit) begin
				o_reg_rdata <= rd_val;
				o_reg_ack <= 1'b1;
			end else begin
				o_reg_err <= 1'b1;
			end
		end
	end
end

endmodule // dpc_top

/* test/dpc_trig_model.sv */
// Trigger source model for both capture inputs
`timescale 1ns/1ps
module dpc_trig_model (
	input wire i_ref_clk,
	input wire [1:0] i_lvl,
	output logic o_capture_input_one = 1'b0,
	output logic o_capture_input_two = 1'b0
);
	////////////////////////////////////////////////////////////////////////////////
	// Levels move just after an edge and hold for many cycles
	always @(posedge i_ref_clk) begin
		o_capture_input_one <= i_lvl[0];
		o_capture_input_two <= i_lvl[1];
	end
endmodule // dpc_trig_model

/* test/dpc_top_assertions.sv */
// Checker of the capture unit parameter port
`timescale 1ns/1ps
module dpc_chk #(
	parameter POS_W = 32,
	parameter CNT_W = 16
) (
	input wire i_ref_clk,
	input wire i_sys_rst,
	input wire i_capture_input_one,
	input wire i_capture_input_two,
	input wire [POS_W-1:0] i_motor_pos,
	input wire i_pos_redef,
	input wire [POS_W-1:0] i_pos_shift,
	input wire [15:0] i_reg_addr,
	input wire i_reg_rd,
	input wire i_reg_wr,
	input wire [15:0] i_reg_wdata,
	input wire [31:0] o_reg_rdata,
	input wire o_reg_ack,
	input wire o_reg_err
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	////////////////////////////////////////////////////////////////////////////////
	property p_ans; (i_reg_rd || i_reg_wr) |=> (o_reg_ack ^ o_reg_err); endproperty
	a_ans: assert property (p_ans) else $error("no single answer");
	property p_idle; !(i_reg_rd || i_reg_wr) |=> !o_reg_ack && !o_reg_err; endproperty
	a_idle: assert property (p_idle) else $error("answer without request");
	property p_ro; i_reg_wr && i_reg_addr != 16'h1B74 |=> o_reg_err; endproperty
	a_ro: assert property (p_ro) else $error("read-only write accepted");
	property p_keep; !i_reg_rd |=> $stable(o_reg_rdata); endproperty
	a_keep: assert property (p_keep) else $error("read data moved");
	property p_unm; i_reg_rd && !i_reg_wr && i_reg_addr == 16'h0A4B |=> o_reg_err; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read accepted");
	property p_cnt; i_reg_rd && !i_reg_wr && i_reg_addr == 16'h0A56 |=> o_reg_rdata[31:16] == 0;
	endproperty
	a_cnt: assert property (p_cnt) else $error("counter upper bits set");
	property p_ctl; i_reg_rd && !i_reg_wr && i_reg_addr == 16'h1B74
		|=> (o_reg_rdata & ~32'h00003333) == 0; endproperty
	a_ctl: assert property (p_ctl) else $error("control reserved bits set");
	property p_st; i_reg_rd && !i_reg_wr && i_reg_addr == 16'h1B76
		|=> (o_reg_rdata & ~32'h00000707) == 0; endproperty
	a_st: assert property (p_st) else $error("status reserved bits set");
endmodule // dpc_chk
bind dpc_top dpc_chk #(.POS_W(POS_W), .CNT_W(CNT_W)) u_chk (.i_ref_clk(i_ref_clk),
	.i_sys_rst(i_sys_rst), .i_capture_input_one(i_capture_input_one),
	.i_capture_input_two(i_capture_input_two), .i_motor_pos(i_motor_pos),
	.i_pos_redef(i_pos_redef), .i_pos_shift(i_pos_shift), .i_reg_addr(i_reg_addr),
	.i_reg_rd(i_reg_rd), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata),
	.o_reg_rdata(o_reg_rdata), .o_reg_ack(o_reg_ack), .o_reg_err(o_reg_err));

/* test/tb_dual_input_position_capture.sv */
// Testbench of the two-channel position capture unit
`timescale 1ns/1ps
`include "dpc_map.vh"
`define CHK(g, x) begin checks_done++; if ((g) !== (x)) begin num_errors++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, g, x); end end
module tb_dual_input_position_capture;
	logic clk, rst, redef, rd, wr, e, in1, in2;
	logic [31:0] pos, shift, rdata, q;
	logic [15:0] addr, wdata;
	logic [1:0] lvl;
	wire ack, err;
	int num_errors = 0;
	int checks_done = 0;
	dpc_trig_model u_trig (.i_ref_clk(clk), .i_lvl(lvl), .o_capture_input_one(in1),
		.o_capture_input_two(in2));
	dpc_top DUT (.i_ref_clk(clk), .i_sys_rst(rst), .i_capture_input_one(in1),
		.i_capture_input_two(in2), .i_motor_pos(pos), .i_pos_redef(redef), .i_pos_shift(shift),
		.i_reg_addr(addr), .i_reg_rd(rd), .i_reg_wr(wr), .i_reg_wdata(wdata),
		.o_reg_rdata(rdata), .o_reg_ack(ack), .o_reg_err(err));
	////////////////////////////////////////////////////////////////////////////////
	task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
		int n;
		@(posedge clk);
		addr <= a;
		rd <= !w;
		wr <= w;
		wdata <= d;
		@(posedge clk);
		rd <= 1'b0;
		wr <= 1'b0;
		n = 0;
		#1;
		while (!(ack === 1'b1 || err === 1'b1) && n < 4) begin
			@(posedge clk);
			#1;
			n++;
		end
		`CHK(ack | err, 1'b1)
		q = rdata;
		e = err;
	endtask
	task automatic rdchk(input logic [15:0] a, input logic [31:0] x);
		acc(1'b0, a, 16'h0000);
		`CHK(e, 1'b0)
		`CHK(q, x)
	endtask
	task automatic toggle(input int ch, input logic v, input logic [31:0] p);
		@(posedge clk);
		pos <= p;
		@(posedge clk);
		lvl[ch] <= v;
		repeat (8) @(posedge clk);
	endtask
	task automatic arm(input logic [15:0] c);
		acc(1'b1, `DPC_OFS_CTRL, c);
		repeat (3) @(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		for (int i = 0; i < 4; i++) begin
			rdchk(`DPC_OFS_IN1_RISE_POS + 2 * i, 32'h00000000);
			rdchk(`DPC_OFS_IN1_RISE_CNT + 2 * i, 32'h00000000);
		end
		rdchk(`DPC_OFS_SUMMARY, 32'h00000000);
	endtask
	task automatic t_capture;
		arm(16'h3133);
		toggle(0, 1'b1, 32'h00001234);
		toggle(0, 1'b0, 32'hFFFFFF00);
		toggle(0, 1'b1, 32'h00000777);
		for (int i = 0; i < 4; i++) toggle(1, i[0] ? 1'b0 : 1'b1, 32'h55 + 32'h11 * i);
		rdchk(`DPC_OFS_IN1_RISE_POS, 32'h00000777);
		rdchk(`DPC_OFS_IN1_FALL_POS, 32'hFFFFFF00);
		rdchk(`DPC_OFS_IN2_RISE_POS, 32'h00000055);
		rdchk(`DPC_OFS_IN2_FALL_POS, 32'h00000066);
		rdchk(`DPC_OFS_IN1_RISE_CNT, 32'h00000002);
		rdchk(`DPC_OFS_IN2_FALL_CNT, 32'h00000001);
		rdchk(`DPC_OFS_SUMMARY, 32'h00001112);
		rdchk(`DPC_OFS_STAT, 32'h00000707);
		rdchk(`DPC_OFS_CTRL, 32'h00003133);
	endtask
	task automatic t_redef;
		@(posedge clk);
		redef <= 1'b1;
		shift <= 32'h00000010;
		@(posedge clk);
		redef <= 1'b0;
		rdchk(`DPC_OFS_IN1_RISE_POS, 32'h00000787);
		rdchk(`DPC_OFS_IN1_FALL_POS, 32'hFFFFFF10);
	endtask
	task automatic t_rearm;
		arm(16'h0000);
		rdchk(`DPC_OFS_STAT, 32'h00000606);
		arm(16'h1133);
		rdchk(`DPC_OFS_STAT, 32'h00000101);
		rdchk(`DPC_OFS_IN1_RISE_CNT, 32'h00000000);
		rdchk(`DPC_OFS_IN2_FALL_CNT, 32'h00000000);
		toggle(1, 1'b1, 32'h00000099);
		toggle(1, 1'b0, 32'h000000AA);
		rdchk(`DPC_OFS_IN2_RISE_POS, 32'h00000099);
		rdchk(`DPC_OFS_IN2_FALL_POS, 32'h00000076);
		rdchk(`DPC_OFS_IN2_FALL_CNT, 32'h00000000);
		rdchk(`DPC_OFS_IN2_RISE_CNT, 32'h00000001);
		rdchk(`DPC_OFS_STAT, 32'h00000301);
		acc(1'b1, `DPC_OFS_IN1_RISE_POS, 16'hAAAA);
		`CHK(e, 1'b1)
		acc(1'b0, 16'h0A4B, 16'h0000);
		`CHK(e, 1'b1)
		rdchk(`DPC_OFS_IN1_RISE_POS, 32'h00000787);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		$display("Checks %0d, errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		#50000;
		num_errors++;
		print_verdict;
	end
	initial begin
		{rst, redef, rd, wr, lvl, addr, wdata, pos, shift} = 0;
		rst = 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_capture;
		t_redef;
		t_rearm;
		print_verdict;
	end
endmodule // tb_dual_input_position_capture
